// ===== verilog/fsw_pkg.sv
// constants, types and helpers for the flash program/erase/wrap sequencer
// Behaviour
// [R1] host sends 77h, 24 dummy bits, wrap byte
// [R2] wrap acts only on quad io reads, spi
// [R3] disable resets one; length codes 8..64 bytes
// [R4] host leaves wrap by writing disable one
// [R5] program and erase need write enable latch
// [R6] host sends 02h, three address, data bytes
// [R7] data past page end wraps to page start
// [R8] over 256 bytes keeps only last 256
// [R9] short data leaves other page bytes untouched
// [R10] program needs select high on byte boundary
// [R11] program cycle sets busy, clears write latch
// [R12] program to protected page is refused
// [R13] quad program 32h needs quad enable bit
// [R14] sector erase 20h erases whole sector
// [R15] block erase 52h erases whole 32k block
// [R16] block erase d8h erases whole 64k block
// [R17] erase needs select high after address
// [R18] erase cycle sets busy, clears write latch
// [R19] erase of protected area is refused
// [R20] host holds select low whole sequence
// [R21] wrapped read restarts at section start
// [R22] busy device ignores program and erase
package fsw_pkg;

  // system clock period
  localparam int CLK_PERIOD_NS = 50;

  // opcodes
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;

  // wrap byte layout and reset values
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_LSB = 5;
  localparam logic WRAP_DIS_RESET = 1'b1;
  localparam logic [1:0] WRAP_LEN_RESET = 2'h0;

  // address bytes per command, minus one
  localparam logic [1:0] ADDR_LAST = 2'h2;

  // alignment masks of the erase units
  localparam logic [23:0] SECTOR_MASK = 24'h00_0fff;
  localparam logic [23:0] BLK32_MASK = 24'h00_7fff;
  localparam logic [23:0] BLK64_MASK = 24'h00_ffff;

  // self-timed cycle durations
  localparam int PAGE_PROG_TIME_US = 600;
  localparam int SECTOR_ERASE_TIME_US = 100_000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 300_000;
  localparam int LARGE_BLOCK_ERASE_TIME_US = 500_000;
  localparam int PROG_CYCLES = PAGE_PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SECTOR_CYCLES = SECTOR_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BLK32_CYCLES =
    SMALL_BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BLK64_CYCLES =
    LARGE_BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;

  // frame phases
  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_DATA, PH_DONE, PH_SKIP
  } fsw_phase_t;

  // decoded commands
  typedef enum logic [2:0] {
    CMD_NONE, CMD_WRAP, CMD_PROG, CMD_QPROG, CMD_SE, CMD_ERASE_32K_BLOCK_COMMAND, CMD_ERASE_64K_BLOCK_COMMAND
  } fsw_cmd_t;

  // erase unit sizes
  typedef enum logic [1:0] {
    ERASE_SECTOR, ERASE_32K, ERASE_64K
  } fsw_esize_t;

  // protection: low three bits n protect 2^(n-1) 64k blocks at the top,
  // bit 3 moves the area to the bottom; every erase unit sits in one
  // 64k block so checking that block is enough
  function automatic logic fsw_protected(input logic [4:0] bp,
                                         input logic [23:0] addr);
    logic [6:0] cnt;
    logic [6:0] blk;
    cnt = 7'h00;
    blk = {1'b0, addr[21:16]};
    if (bp[2:0] != 3'h0) begin
      cnt = 7'(7'h01 << (bp[2:0] - 3'h1));
    end
    if (bp[3]) begin
      return blk < cnt;
    end
    return (cnt != 7'h00) && (blk >= 7'(7'h40 - cnt));
  endfunction : fsw_protected

endpackage : fsw_pkg

// ===== verilog/fsw_page_ram.sv
// page buffer of 256 bytes with a registered read port
`timescale 1ns/1ns
`default_nettype none
module fsw_page_ram (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  // storage, no reset: validity is tracked by the sequencer
  logic [7:0] mem [256];

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : fsw_page_ram
`default_nettype wire

// ===== verilog/fsw_sequencer.sv
// serial flash program, erase and wrap-setting command sequencer
`timescale 1ns/1ns
`default_nettype none
module fsw_sequencer #(
  parameter int PROG_CYCLES = fsw_pkg::PROG_CYCLES,
  parameter int SECTOR_CYCLES = fsw_pkg::SECTOR_CYCLES,
  parameter int BLK32_CYCLES = fsw_pkg::BLK32_CYCLES,
  parameter int BLK64_CYCLES = fsw_pkg::BLK64_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // spi pins, sampled
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  // status and control from the rest of the device
  input wire logic write_enable_command_i,
  input wire logic write_disable_command_i,
  input wire logic quad_enable_bit_i,
  input wire logic quad_command_mode_i,
  input wire logic [4:0] block_protection_bits_i,
  // read address generator
  input wire logic rd_start_i,
  input wire logic [23:0] rd_start_addr_i,
  input wire logic rd_step_i,
  input wire logic rd_quad_io_i,
  output logic [23:0] rd_addr_o,
  // status
  output logic write_in_progress_flag_o,
  output logic write_enable_latch_o,
  output logic wrap_disable_bit_o,
  output logic [1:0] wrap_length_bits_o,
  // array port
  output logic arr_prog_o,
  output logic arr_erase_o,
  output logic [1:0] arr_erase_size_o,
  output logic [23:0] arr_addr_o,
  output logic [7:0] arr_data_o
);

  // all state in one record
  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic [3:0] io_m;
    logic [3:0] io_s;
    fsw_pkg::fsw_phase_t phase;
    fsw_pkg::fsw_cmd_t cmd;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [23:0] addr;
    logic data_seen;
    logic [255:0] loaded;
    logic write_enable_latch;
    logic write_in_progress_flag;
    logic [23:0] timer;
    logic streaming;
    logic [8:0] stream_idx;
    logic rd_valid;
    logic [7:0] rd_idx;
    logic [15:0] page;
    logic wrap_dis;
    logic [1:0] wrap_len;
    logic [23:0] rd_addr;
    logic prog;
    logic erase;
    fsw_pkg::fsw_esize_t esize;
    logic [23:0] arr_addr;
    logic [7:0] arr_data;
  } fsw_state_t;

  fsw_state_t st_reg; // registered state
  fsw_state_t st_next; // next state
  logic wr_en; // page buffer write strobe
  logic [7:0] rd_data; // page buffer read data
  logic sclk_rise; // sampled clock rising edge
  logic frame_end; // sampled select rising edge

  assign sclk_rise = st_reg.sclk_s & ~st_reg.sclk_d;
  assign frame_end = st_reg.cs_s & ~st_reg.cs_d;

  // page buffer holds the bytes latched in a program frame
  fsw_page_ram u_page (
    .clk_i(sys_clk_i),
    .wr_en_i(wr_en),
    .wr_addr_i(st_reg.addr[7:0]),
    .wr_data_i(st_next.shift),
    .rd_addr_i(st_reg.stream_idx[7:0]),
    .rd_data_o(rd_data)
  );

  // whole next-state logic
  always_comb begin
    logic quad;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] wmask;
    quad = 1'b0;
    cnt = 4'h0;
    sh = 8'h00;
    wmask = 8'h00;
    st_next = st_reg;
    wr_en = 1'b0;
    // two-stage synchronisers, then one delay for edge finding
    st_next.sclk_m = sclk_i;
    st_next.sclk_s = st_reg.sclk_m;
    st_next.sclk_d = st_reg.sclk_s;
    st_next.cs_m = cs_n_i;
    st_next.cs_s = st_reg.cs_m;
    st_next.cs_d = st_reg.cs_s;
    st_next.io_m = io_i;
    st_next.io_s = st_reg.io_m;
    st_next.prog = 1'b0;
    st_next.erase = 1'b0;

    // bit capture inside a frame
    if (!st_reg.cs_s && sclk_rise) begin
      // quad program carries address and data on all four lines
      quad = (st_reg.cmd == fsw_pkg::CMD_QPROG) &&
             (st_reg.phase != fsw_pkg::PH_CMD); // see [R13]
      sh = quad ? {st_reg.shift[3:0], st_reg.io_s}
                : {st_reg.shift[6:0], st_reg.io_s[0]};
      cnt = {1'b0, st_reg.bit_cnt} + (quad ? 4'h4 : 4'h1);
      st_next.shift = sh;
      st_next.bit_cnt = cnt[2:0];
      // any clock after the last address bit spoils an erase
      if (st_reg.phase == fsw_pkg::PH_DONE &&
          st_reg.cmd != fsw_pkg::CMD_WRAP) begin
        st_next.phase = fsw_pkg::PH_SKIP; // see [R17]
      end else if (cnt[3]) begin
        unique case (st_reg.phase)
          fsw_pkg::PH_CMD: begin
            st_next.phase = fsw_pkg::PH_ADDR;
            st_next.byte_cnt = 2'h0;
            case (sh)
              fsw_pkg::OP_SET_WRAP: st_next.cmd = fsw_pkg::CMD_WRAP;
              fsw_pkg::OP_PAGE_PROG: st_next.cmd = fsw_pkg::CMD_PROG;
              fsw_pkg::OP_QUAD_PROG: st_next.cmd = fsw_pkg::CMD_QPROG;
              fsw_pkg::OP_SECTOR_ERASE: st_next.cmd = fsw_pkg::CMD_SE;
              fsw_pkg::OP_ERASE_32K: st_next.cmd = fsw_pkg::CMD_ERASE_32K_BLOCK_COMMAND;
              fsw_pkg::OP_ERASE_64K: st_next.cmd = fsw_pkg::CMD_ERASE_64K_BLOCK_COMMAND;
              default: st_next.phase = fsw_pkg::PH_SKIP;
            endcase
            // quad program without the enable bit is not decoded
            if (sh == fsw_pkg::OP_QUAD_PROG && !quad_enable_bit_i) begin
              st_next.phase = fsw_pkg::PH_SKIP; // see [R13]
            end
            // busy: only the wrap setting still gets through
            if (st_reg.write_in_progress_flag && sh != fsw_pkg::OP_SET_WRAP) begin
              st_next.phase = fsw_pkg::PH_SKIP; // see [R22]
            end
            // fresh program frame starts with an empty page image
            st_next.loaded = '0; // see [R9]
            st_next.data_seen = 1'b0;
          end
          fsw_pkg::PH_ADDR: begin
            // 24 address bits, or 24 dummy bits for the wrap setting
            st_next.addr = {st_reg.addr[15:0], sh}; // see [R6]
            st_next.byte_cnt = st_reg.byte_cnt + 2'h1;
            if (st_reg.byte_cnt == fsw_pkg::ADDR_LAST) begin
              st_next.phase = (st_reg.cmd == fsw_pkg::CMD_WRAP ||
                               st_reg.cmd == fsw_pkg::CMD_PROG ||
                               st_reg.cmd == fsw_pkg::CMD_QPROG)
                              ? fsw_pkg::PH_DATA : fsw_pkg::PH_DONE;
            end
          end
          fsw_pkg::PH_DATA: begin
            if (st_reg.cmd == fsw_pkg::CMD_WRAP) begin
              // wrap byte takes effect as soon as it is complete
              st_next.wrap_dis = sh[fsw_pkg::WRAP_DIS_POS]; // see [R3]
              st_next.wrap_len = sh[fsw_pkg::WRAP_LEN_LSB +: 2];
              st_next.phase = fsw_pkg::PH_DONE;
            end else begin
              // low address byte rolls over inside the page, so a
              // later byte to the same slot replaces the earlier one
              wr_en = 1'b1; // see [R8]
              st_next.loaded[st_reg.addr[7:0]] = 1'b1;
              st_next.addr[7:0] = st_reg.addr[7:0] + 8'h01; // see [R7]
              st_next.data_seen = 1'b1;
            end
          end
          default: begin
            // done or skipped: later bits are dropped
          end
        endcase
      end
    end

    // select high: decide and clear the frame
    if (frame_end && !st_reg.write_in_progress_flag) begin
      if ((st_reg.cmd == fsw_pkg::CMD_PROG ||
           st_reg.cmd == fsw_pkg::CMD_QPROG) &&
          st_reg.phase == fsw_pkg::PH_DATA && st_reg.bit_cnt == 3'h0 &&
          st_reg.data_seen && st_reg.write_enable_latch && // see [R5] [R10]
          !fsw_pkg::fsw_protected(block_protection_bits_i,
                                  st_reg.addr)) begin // see [R12]
        st_next.write_in_progress_flag = 1'b1; // see [R11]
        st_next.write_enable_latch = 1'b0;
        st_next.timer = 24'(PROG_CYCLES);
        st_next.streaming = 1'b1;
        st_next.stream_idx = 9'h000;
        st_next.page = st_reg.addr[23:8];
      end
      if ((st_reg.cmd == fsw_pkg::CMD_SE ||
           st_reg.cmd == fsw_pkg::CMD_ERASE_32K_BLOCK_COMMAND ||
           st_reg.cmd == fsw_pkg::CMD_ERASE_64K_BLOCK_COMMAND) &&
          st_reg.phase == fsw_pkg::PH_DONE && st_reg.write_enable_latch && // see [R17]
          !fsw_pkg::fsw_protected(block_protection_bits_i,
                                  st_reg.addr)) begin // see [R19]
        st_next.write_in_progress_flag = 1'b1; // see [R18]
        st_next.write_enable_latch = 1'b0;
        st_next.erase = 1'b1;
        // whole unit around the given address
        if (st_reg.cmd == fsw_pkg::CMD_SE) begin
          st_next.arr_addr = st_reg.addr & ~fsw_pkg::SECTOR_MASK; // see [R14]
          st_next.esize = fsw_pkg::ERASE_SECTOR;
          st_next.timer = 24'(SECTOR_CYCLES);
        end else if (st_reg.cmd == fsw_pkg::CMD_ERASE_32K_BLOCK_COMMAND) begin
          st_next.arr_addr = st_reg.addr & ~fsw_pkg::BLK32_MASK; // see [R15]
          st_next.esize = fsw_pkg::ERASE_32K;
          st_next.timer = 24'(BLK32_CYCLES);
        end else begin
          st_next.arr_addr = st_reg.addr & ~fsw_pkg::BLK64_MASK; // see [R16]
          st_next.esize = fsw_pkg::ERASE_64K;
          st_next.timer = 24'(BLK64_CYCLES);
        end
      end
    end
    if (st_reg.cs_s) begin
      st_next.phase = fsw_pkg::PH_CMD;
      st_next.cmd = fsw_pkg::CMD_NONE;
      st_next.bit_cnt = 3'h0;
      st_next.byte_cnt = 2'h0;
    end

    // self-timed cycle countdown
    if (st_reg.write_in_progress_flag) begin
      st_next.timer = st_reg.timer - 24'h00_0001;
      if (st_reg.timer == 24'h00_0001) begin
        st_next.write_in_progress_flag = 1'b0; // see [R11] [R18]
      end
    end

    // program cycle streams the loaded bytes to the array;
    // untouched slots are skipped so the array keeps them
    if (st_reg.streaming) begin
      st_next.stream_idx = st_reg.stream_idx + 9'h001;
      st_next.streaming = (st_reg.stream_idx[7:0] != 8'hff);
    end
    st_next.rd_valid = st_reg.streaming;
    st_next.rd_idx = st_reg.stream_idx[7:0];
    if (st_reg.rd_valid && st_reg.loaded[st_reg.rd_idx]) begin
      st_next.prog = 1'b1; // see [R9]
      st_next.arr_addr = {st_reg.page, st_reg.rd_idx};
      st_next.arr_data = rd_data;
    end

    // read address generator with optional wrap inside the page
    unique case (st_reg.wrap_len)
      2'h0: wmask = 8'h07;
      2'h1: wmask = 8'h0f;
      2'h2: wmask = 8'h1f;
      2'h3: wmask = 8'h3f;
    endcase
    if (rd_start_i) begin
      st_next.rd_addr = rd_start_addr_i;
    end else if (rd_step_i) begin
      if (!st_reg.wrap_dis && rd_quad_io_i && !quad_command_mode_i) begin
        st_next.rd_addr[7:0] = (st_reg.rd_addr[7:0] & ~wmask) |
          ((st_reg.rd_addr[7:0] + 8'h01) & wmask); // see [R2] [R21]
      end else begin
        st_next.rd_addr = st_reg.rd_addr + 24'h00_0001;
      end
    end

    // write enable latch: a set in the same cycle wins over any clear
    if (write_disable_command_i) begin
      st_next.write_enable_latch = 1'b0;
    end
    if (write_enable_command_i) begin
      st_next.write_enable_latch = 1'b1; // see [R5]
    end
  end

  // state register; wrap starts disabled
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
      st_reg.sclk_m <= 1'b0;
      st_reg.cs_m <= 1'b1;
      st_reg.cs_s <= 1'b1;
      st_reg.cs_d <= 1'b1;
      st_reg.wrap_dis <= fsw_pkg::WRAP_DIS_RESET; // see [R3]
      st_reg.wrap_len <= fsw_pkg::WRAP_LEN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign rd_addr_o = st_reg.rd_addr;
  assign write_in_progress_flag_o = st_reg.write_in_progress_flag;
  assign write_enable_latch_o = st_reg.write_enable_latch;
  assign wrap_disable_bit_o = st_reg.wrap_dis;
  assign wrap_length_bits_o = st_reg.wrap_len;
  assign arr_prog_o = st_reg.prog;
  assign arr_erase_o = st_reg.erase;
  assign arr_erase_size_o = st_reg.esize;
  assign arr_addr_o = st_reg.arr_addr;
  assign arr_data_o = st_reg.arr_data;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence cycle_start_s;
    !write_in_progress_flag_o ##1 write_in_progress_flag_o;
  endsequence

  sequence frame_close_s;
    st_reg.cs_s && !st_reg.cs_d;
  endsequence

  wel_needed_a: assert property ( // see [R5]
    cycle_start_s |-> $past(st_reg.write_enable_latch, 2) || $past(write_enable_command_i, 2))
    else $error("cycle started without write enable latch");

  start_on_frame_a: assert property ( // see [R10]
    cycle_start_s |-> $past(frame_end))
    else $error("cycle started outside a select rising edge");

  wel_cleared_a: assert property ( // see [R11]
    cycle_start_s |-> !write_enable_latch_o || $past(write_enable_command_i))
    else $error("write enable latch not cleared at cycle start");

  busy_holds_a: assert property ( // see [R18]
    cycle_start_s |=> write_in_progress_flag_o [*8])
    else $error("busy flag dropped too early");

  erase_units_a: assert property ( // see [R14] [R15] [R16]
    arr_erase_o |-> ((arr_erase_size_o == 2'h0) ?
      (arr_addr_o & fsw_pkg::SECTOR_MASK) == 24'h00_0000 :
      (arr_erase_size_o == 2'h1) ?
      (arr_addr_o & fsw_pkg::BLK32_MASK) == 24'h00_0000 :
      (arr_addr_o & fsw_pkg::BLK64_MASK) == 24'h00_0000))
    else $error("erase unit not aligned");

  erase_prot_a: assert property ( // see [R19]
    arr_erase_o |-> !fsw_pkg::fsw_protected(
      $past(block_protection_bits_i), arr_addr_o))
    else $error("protected area erased");

  busy_ignore_a: assert property ( // see [R22]
    arr_erase_o |-> $past(!write_in_progress_flag_o) && $past(frame_end))
    else $error("erase started while busy");

  prog_page_a: assert property ( // see [R7]
    arr_prog_o ##1 arr_prog_o |-> arr_addr_o[23:8] == $past(arr_addr_o[23:8]))
    else $error("program left its page");

  prog_in_cycle_a: assert property ( // see [R11]
    arr_prog_o |-> write_in_progress_flag_o)
    else $error("array programmed outside a cycle");

  wrap_section_a: assert property ( // see [R21]
    rd_step_i && !rd_start_i && rd_quad_io_i && !quad_command_mode_i &&
    !wrap_disable_bit_o |=> rd_addr_o[23:6] == $past(rd_addr_o[23:6]))
    else $error("wrapped read left its section");

endmodule : fsw_sequencer
`default_nettype wire

// ===== bench/fsw_host_model.sv
// host spi controller model that drives the flash pins
`timescale 1ns/1ns
`default_nettype none
module fsw_host_model (
  // system clock, only paces the pins
  input wire logic clk_i,
  // spi pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o
);
  // idle: deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h0;
  end

  // half an sclk period: 4 system clocks, so sclk runs at 400 ns
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask : half

  // select the device and keep it selected to the last bit
  task automatic open_frame();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    half();
  endtask : open_frame

  // beats of one byte, msb first; quad sends two nibbles, high first
  task automatic put_byte(input logic [7:0] b, input logic quad,
                          input int beats);
    for (int i = 0; i < beats; i++) begin
      if (quad) begin
        io_o = (i == 0) ? b[7:4] : b[3:0];
      end else begin
        // unused lines keep toggling so nothing leans on them
        io_o = {io_o[3:1] ^ 3'h7, b[7 - i]};
      end
      half();
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
  endtask : put_byte

  // deselect; released lines show the inverse of the last value
  task automatic close_frame();
    cs_n_o = 1'b1;
    io_o = ~io_o;
    half();
    half();
  endtask : close_frame
endmodule : fsw_host_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench of the program, erase and wrap sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // clock, reset and side inputs
  logic sys_clk, resetn, wen, wdis, qe, qmode, rd_go, rd_inc, rd_q;
  logic [4:0] bp;
  logic [23:0] rd_at;
  // pins from the host model
  logic cs_n, sclk;
  logic [3:0] io;
  // design outputs
  logic write_in_progress_flag, write_enable_latch, w_dis, a_prog, a_er;
  logic [1:0] w_len, a_size;
  logic [23:0] rd_addr, a_addr, er_addr, p_addr;
  logic [7:0] a_data;
  // record of array requests
  logic [7:0] pmem [256];
  logic [1:0] er_size;
  int n_prog = 0;
  int n_er = 0;
  int n_fail = 0;
  int tests_run = 0;

  // short cycle counts keep the run brief; sector stays long for busy
  fsw_sequencer #(.PROG_CYCLES(300), .SECTOR_CYCLES(2000),
    .BLK32_CYCLES(20), .BLK64_CYCLES(20)) fsw_sequencer_i (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .cs_n_i(cs_n),
    .sclk_i(sclk), .io_i(io), .write_enable_command_i(wen),
    .write_disable_command_i(wdis), .quad_enable_bit_i(qe),
    .quad_command_mode_i(qmode), .block_protection_bits_i(bp),
    .rd_start_i(rd_go), .rd_start_addr_i(rd_at), .rd_step_i(rd_inc),
    .rd_quad_io_i(rd_q), .rd_addr_o(rd_addr),
    .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch),
    .wrap_disable_bit_o(w_dis), .wrap_length_bits_o(w_len),
    .arr_prog_o(a_prog), .arr_erase_o(a_er), .arr_erase_size_o(a_size),
    .arr_addr_o(a_addr), .arr_data_o(a_data));

  fsw_host_model fsw_host_model_i (.clk_i(sys_clk), .cs_n_o(cs_n),
    .sclk_o(sclk), .io_o(io));

  // 50 ns system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // capture every array request as it pulses
  always @(posedge sys_clk) begin
    if (a_prog) begin
      pmem[a_addr[7:0]] <= a_data;
      p_addr <= a_addr;
      n_prog <= n_prog + 1;
    end
    if (a_er) begin
      er_addr <= a_addr;
      er_size <= a_size;
      n_er <= n_er + 1;
    end
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict, the one end of the run
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // bounded wait for the busy flag
  task automatic wait_wip(input logic v, input int lim);
    for (int i = 0; i < lim && write_in_progress_flag !== v; i++) @(negedge sys_clk);
  endtask : wait_wip

  // one-cycle pulse on a latch command input
  task automatic pulse(input logic dis);
    @(negedge sys_clk);
    if (dis) wdis = 1'b1;
    else wen = 1'b1;
    @(negedge sys_clk);
    wen = 1'b0;
    wdis = 1'b0;
  endtask : pulse

  // data pattern whose second lap differs from the first
  function automatic logic [7:0] dat(input int i);
    return 8'(i) ^ (8'(i >> 8) * 8'h55);
  endfunction : dat

  // whole frame: opcode, address, data bytes, then stray beats
  task automatic frame(input logic [7:0] op, input logic [23:0] a,
    input int nd, input logic q, input int extra, input logic [7:0] d0);
    fsw_host_model_i.open_frame();
    fsw_host_model_i.put_byte(op, 1'b0, 8);
    for (int k = 2; k >= 0; k--)
      fsw_host_model_i.put_byte(a[k*8 +: 8], q, q ? 2 : 8);
    for (int i = 0; i < nd; i++)
      fsw_host_model_i.put_byte(dat(i) ^ d0, q, q ? 2 : 8);
    if (extra > 0) fsw_host_model_i.put_byte(8'h00, 1'b0, extra);
    fsw_host_model_i.close_frame();
  endtask : frame

  // a frame that must leave the busy flag alone
  task automatic t_refuse(input logic en, input logic [7:0] op,
    input logic [23:0] a, input int nd, input logic q, input int extra);
    if (en) pulse(1'b0);
    frame(op, a, nd, q, extra, 8'h00);
    repeat (20) @(negedge sys_clk);
    check(write_in_progress_flag, 1'b0);
    pulse(1'b1);
  endtask : t_refuse

  // each erase size: aligned base, busy, latch cleared
  task automatic t_erase();
    logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hd8};
    logic [23:0] base [3] = '{24'h12_b000, 24'h12_8000, 24'h12_0000};
    for (int k = 0; k < 3; k++) begin
      pulse(1'b0);
      frame(ops[k], 24'h12_b456, 0, 1'b0, 0, 8'h00);
      wait_wip(1'b1, 10);
      check({write_in_progress_flag, write_enable_latch, er_size}, {2'b10, 2'(k)});
      check(er_addr, base[k]);
      wait_wip(1'b0, 2100);
      check(write_in_progress_flag, 1'b0);
    end
  endtask : t_erase

  // busy device ignores a second erase
  task automatic t_busy();
    int n0;
    pulse(1'b0);
    frame(8'h20, 24'h00_1000, 0, 1'b0, 0, 8'h00);
    wait_wip(1'b1, 10);
    n0 = n_er;
    pulse(1'b0);
    frame(8'h52, 24'h00_8000, 0, 1'b0, 0, 8'h00);
    repeat (10) @(negedge sys_clk);
    check({write_in_progress_flag, 24'(n_er)}, {1'b1, 24'(n0)});
    wait_wip(1'b0, 2100);
    pulse(1'b1);
  endtask : t_busy

  // program nd bytes from a; page wrap and overwrite expected
  task automatic t_prog(input logic [7:0] op, input logic q,
    input logic [23:0] a, input int nd);
    logic [7:0] exp [256];
    for (int i = 0; i < 256; i++) begin
      pmem[i] = 8'hxx;
      exp[i] = 8'hxx;
    end
    n_prog = 0;
    for (int i = 0; i < nd; i++) exp[8'(a[7:0] + i)] = dat(i);
    pulse(1'b0);
    frame(op, a, nd, q, 0, 8'h00);
    wait_wip(1'b1, 10);
    check({write_in_progress_flag, write_enable_latch}, 2'b10);
    wait_wip(1'b0, 400);
    check(write_in_progress_flag, 1'b0);
    check(n_prog, (nd > 256) ? 256 : nd);
    check(p_addr[23:8], a[23:8]);
    for (int i = 0; i < 256; i++) check(pmem[i], exp[i]);
  endtask : t_prog

  // load a read address and take one step
  task automatic rd(input logic [23:0] s, input logic q);
    @(negedge sys_clk);
    rd_go = 1'b1;
    rd_at = s;
    rd_q = q;
    @(negedge sys_clk);
    rd_go = 1'b0;
    rd_inc = 1'b1;
    @(negedge sys_clk);
    rd_inc = 1'b0;
    @(negedge sys_clk);
  endtask : rd

  // every wrap length, then linear reads again
  task automatic t_wrap();
    for (int n = 0; n < 4; n++) begin
      frame(8'h77, 24'h00_0000, 1, 1'b0, 0, {1'b0, 2'(n), 5'h00});
      repeat (4) @(negedge sys_clk);
      check({w_dis, w_len}, {1'b0, 2'(n)});
      rd(24'h00_0340 + 24'((8 << n) - 1), 1'b1);
      check(rd_addr, 24'h00_0340);
    end
    rd(24'h00_037f, 1'b0);
    check(rd_addr, 24'h00_0380);
    frame(8'h77, 24'h00_0000, 1, 1'b0, 0, 8'h70);
    repeat (4) @(negedge sys_clk);
    rd(24'h00_037f, 1'b1);
    check({w_dis, rd_addr}, {1'b1, 24'h00_0380});
  endtask : t_wrap

  // hang guard, well past the expected 1.3 ms
  initial begin
    #4_000_000;
    n_fail++;
    conclude();
  end

  // main sequence
  initial begin
    {resetn, wen, wdis, qe, qmode, rd_go, rd_inc, rd_q} = 8'h00;
    bp = 5'h00;
    rd_at = 24'h00_0000;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({write_in_progress_flag, write_enable_latch, w_dis, w_len}, 5'b00100);
    t_refuse(1'b0, 8'h20, 24'h00_1000, 0, 1'b0, 0);
    t_refuse(1'b1, 8'h20, 24'h00_1000, 0, 1'b0, 1);
    t_refuse(1'b1, 8'h02, 24'h00_1000, 1, 1'b0, 4);
    t_refuse(1'b1, 8'h32, 24'h00_1000, 1, 1'b1, 0);
    bp = 5'h01;
    t_refuse(1'b1, 8'hd8, 24'h3f_0000, 0, 1'b0, 0);
    t_refuse(1'b1, 8'h02, 24'h3f_0000, 1, 1'b0, 0);
    bp = 5'h00;
    t_erase();
    t_busy();
    t_prog(8'h02, 1'b0, 24'h00_12fe, 3);
    qe = 1'b1;
    t_prog(8'h32, 1'b1, 24'h00_2010, 2);
    t_prog(8'h02, 1'b0, 24'h00_3040, 258);
    t_wrap();
    conclude();
  end
endmodule : testbench
`default_nettype wire
